// >>> logic/pcs_pkg.sv
// Package for the power-management configuration and status register bank
package pcs_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CHG_TWO = 8'h05;
    localparam logic [7:0] OFS_CHG_THREE = 8'h06;
    localparam logic [7:0] OFS_BL_CTRL = 8'h07;
    localparam logic [7:0] OFS_BL_DUTY = 8'h08;
    localparam logic [7:0] OFS_MUX = 8'h09;
    localparam logic [7:0] OFS_STATE = 8'h0A;
    localparam logic [7:0] OFS_KEY = 8'h0B;
    localparam logic [7:0] OFS_GOOD = 8'h0C;
    localparam logic [7:0] OFS_GOOD_CTRL = 8'h0D;
    localparam logic [7:0] OFS_BUCK_ONE = 8'h0E;
    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CHG_TWO = 8'h80;
    localparam logic [7:0] RST_CHG_THREE = 8'hB2;
    localparam logic [7:0] RST_BL_CTRL = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_GOOD_CTRL = 8'h0C;
    localparam logic [7:0] MSK_CHG_TWO = 8'hF0;
    localparam logic [7:0] MSK_STATE_RW = 8'h70;
    localparam logic [7:0] MSK_GOOD_RW = 8'h80;
    localparam logic [7:0] UNLOCK_VALUE = 8'h7D;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_HALF_RATE = 7;
    localparam int B_PRE_THRESH = 6;
    localparam int B_PRE_TIME = 3;
    localparam int B_SINK_EN = 3;
    localparam int B_SINK_LEVEL = 2;
    localparam int B_OFF_REQ = 7;
    localparam int B_ADAPTER = 3;
    localparam int B_USB = 2;
    localparam int B_BUTTON = 0;
    localparam int B_MASK_A = 3;
    localparam int B_MASK_B = 2;
    localparam int B_EXT_ADJ = 7;
    localparam logic [6:0] DUTY_MAX_CODE = 7'h63;
    localparam logic [5:0] BUCK_TOP_CODE = 6'h38;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_20 = 20;
    localparam int MS_100 = 100;
    localparam int MS_200 = 200;
    localparam int MS_400 = 400;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    // Live analog and pin state presented to the bank
    typedef struct packed {
        logic adapter_present;
        logic usb_supply_present;
        logic button_input_pin;
        logic power_enable_pin;
        logic thermal_loop_active;
        logic path_loop_active;
        logic [6:0] rail_in_regulation;
        logic switch_rail_a_is_switch;
        logic switch_rail_b_is_switch;
    } pcs_sense_type;

    // Decoded settings handed to the analog sections
    typedef struct packed {
        logic timer_half_rate;
        logic precharge_threshold_select;
        logic [1:0] charge_voltage_select;
        logic [1:0] charge_current_select;
        logic [1:0] path_threshold_select;
        logic precharge_time_select;
        logic [1:0] termination_factor;
        logic charge_temp_window;
        logic sink_enable;
        logic sink_level_select;
        logic [1:0] dim_frequency_select;
        logic [6:0] dim_duty_percent;
        logic [2:0] analog_source_select;
        logic analog_out_enable;
        logic buck_a_external_adjust;
        logic [5:0] buck_a_voltage_code;
    } pcs_ctrl_type;
endpackage

// >>> logic/pcs_regs.sv
// Configuration and status register bank of the power-management block
`timescale 1ns/1ps
module pcs_regs
    import pcs_pkg::*;
#(
    parameter logic [7:0] BUCK_ONE_RESET = 8'h18,
    parameter int DLY_20_CYC = MS_20 * CYC_PER_MS,
    parameter int DLY_100_CYC = MS_100 * CYC_PER_MS,
    parameter int DLY_200_CYC = MS_200 * CYC_PER_MS,
    parameter int DLY_400_CYC = MS_400 * CYC_PER_MS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic xact_end,
    input wire pcs_pkg::pcs_sense_type sense,
    output logic [7:0] rd_data,
    output pcs_pkg::pcs_ctrl_type ctrl,
    output logic rails_good_pin,
    output logic off_state,
    output logic timer_tick_enable
);
    import pcs_pkg::*;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] chg2_q, chg2_d;
    logic [7:0] chg3_q, chg3_d;
    logic [7:0] blc_q, blc_d;
    logic [7:0] duty_q, duty_d;
    logic [7:0] mux_q, mux_d;
    logic [7:0] st_q, st_d;
    logic [7:0] key_q, key_d;
    logic [7:0] good_rw_q, good_rw_d;
    logic [7:0] gctl_q, gctl_d;
    logic [7:0] buck_q, buck_d;
    // Unlock is one-shot; off request waits for the enable pin
    logic armed_q, armed_d;
    logic off_q, off_d;
    // Read data sits in a flop so the port is registered
    logic [7:0] rd_q, rd_d;
    logic [7:0] flags;
    logic unlocked;

    // ------------------------------------------------------------
    // Unlock, rail flags and register writes
    // ------------------------------------------------------------
    // A key write of the unlock value arms the unlock; the protected write must be the next write
    assign unlocked = armed_q;

    // Rail flags: regulation, or switch mode forces good on two rails
    always_comb begin
        flags = {1'b0, sense.rail_in_regulation};
        flags[6] = sense.rail_in_regulation[6] |
            sense.switch_rail_a_is_switch;
        flags[5] = sense.rail_in_regulation[5] |
            sense.switch_rail_b_is_switch;
        // Spare top bit reads back whatever was written
        flags = flags | (good_rw_q & MSK_GOOD_RW);
    end

    // Register writes and unlock sequencing
    always_comb begin
        chg2_d = chg2_q;
        chg3_d = chg3_q;
        blc_d = blc_q;
        duty_d = duty_q;
        mux_d = mux_q;
        st_d = st_q;
        key_d = key_q;
        good_rw_d = good_rw_q;
        gctl_d = gctl_q;
        buck_d = buck_q;
        armed_d = armed_q;
        off_d = off_q;
        // Any finished transaction after the key write clears it
        if (xact_end && !(wr_en && addr == OFS_KEY)) begin
            key_d = RST_ZERO;
        end
        // Off request waits for the enable pin to drop, then clears
        // Placed before the writes so a fresh request wins a tie
        if (off_q && !sense.power_enable_pin) begin
            off_d = 1'b0;
        end
        if (wr_en) begin
            // A write anywhere consumes the one-shot unlock
            armed_d = 1'b0;
            if (addr == OFS_CHG_TWO) begin
                // Low nibble is reserved and always reads zero
                chg2_d = wr_data & MSK_CHG_TWO;
            end else if (addr == OFS_CHG_THREE) begin
                chg3_d = wr_data;
            end else if (addr == OFS_BL_CTRL) begin
                blc_d = wr_data;
            end else if (addr == OFS_BL_DUTY) begin
                duty_d = wr_data;
            end else if (addr == OFS_MUX) begin
                mux_d = wr_data;
            end else if (addr == OFS_STATE) begin
                // Only spare bits are stored; off has its own flop
                st_d = wr_data & MSK_STATE_RW;
                if (wr_data[B_OFF_REQ]) begin
                    off_d = 1'b1;
                end
            end else if (addr == OFS_KEY) begin
                key_d = wr_data;
                armed_d = (wr_data == UNLOCK_VALUE);
            end else if (addr == OFS_GOOD) begin
                // Flags are live; only the spare top bit is stored
                good_rw_d = wr_data & MSK_GOOD_RW;
            end else if (addr == OFS_GOOD_CTRL) begin
                if (unlocked) begin
                    gctl_d = wr_data;
                end // Locked write keeps contents
            end else if (addr == OFS_BUCK_ONE) begin
                if (unlocked) begin
                    buck_d = wr_data;
                end // Locked write keeps contents
            end
        end
    end

    // ------------------------------------------------------------
    // Read-back path
    // ------------------------------------------------------------
    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_d = rd_q;
        if (rd_en) begin
            if (addr == OFS_CHG_TWO) begin
                rd_d = chg2_q;
            end else if (addr == OFS_CHG_THREE) begin
                rd_d = chg3_q;
            end else if (addr == OFS_BL_CTRL) begin
                rd_d = blc_q;
            end else if (addr == OFS_BL_DUTY) begin
                rd_d = duty_q;
            end else if (addr == OFS_MUX) begin
                rd_d = mux_q;
            end else if (addr == OFS_STATE) begin
                rd_d = st_q;
                // Live status bits are caught in the read flop
                rd_d[B_OFF_REQ] = off_q;
                rd_d[B_ADAPTER] = sense.adapter_present;
                rd_d[B_USB] = sense.usb_supply_present;
                rd_d[B_BUTTON] = ~sense.button_input_pin;
            end else if (addr == OFS_KEY) begin
                rd_d = key_q;
            end else if (addr == OFS_GOOD) begin
                rd_d = flags;
            end else if (addr == OFS_GOOD_CTRL) begin
                rd_d = gctl_q;
            end else if (addr == OFS_BUCK_ONE) begin
                rd_d = buck_q;
            end else begin
                rd_d = RST_ZERO;
            end
        end
    end

    // Register state; buck reset value is per-variant, hence a parameter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chg2_q <= RST_CHG_TWO;
            chg3_q <= RST_CHG_THREE;
            blc_q <= RST_BL_CTRL;
            duty_q <= RST_ZERO;
            mux_q <= RST_ZERO;
            st_q <= RST_ZERO;
            key_q <= RST_ZERO;
            good_rw_q <= RST_ZERO;
            gctl_q <= RST_GOOD_CTRL;
            buck_q <= BUCK_ONE_RESET;
            armed_q <= 1'b0;
            off_q <= 1'b0;
            rd_q <= RST_ZERO;
        end else begin
            chg2_q <= chg2_d;
            chg3_q <= chg3_d;
            blc_q <= blc_d;
            duty_q <= duty_d;
            mux_q <= mux_d;
            st_q <= st_d;
            key_q <= key_d;
            good_rw_q <= good_rw_d;
            gctl_q <= gctl_d;
            buck_q <= buck_d;
            armed_q <= armed_d;
            off_q <= off_d;
            rd_q <= rd_d;
        end
    end
    assign rd_data = rd_q;

    // ------------------------------------------------------------
    // Timer rate, good-pin delay and off state
    // ------------------------------------------------------------
    // Half-rate toggle and registered tick
    logic half_q, half_d;
    logic tick_q, tick_d;
    // Sticky off state, entered once the enable pin drops
    logic offst_q, offst_d;
    // Good pin flop and its qualifying term
    logic pin_q, pin_d;
    logic raw_good;
    // Counter wide enough for the longest default delay
    logic [24:0] dly_q, dly_d;
    logic [24:0] dly_lim;

    // Masked linear rail flags drop out of the combined good term
    always_comb begin
        raw_good = &flags[6:2];
        if (!gctl_q[B_MASK_A]) begin
            raw_good = raw_good & flags[1];
        end
        if (!gctl_q[B_MASK_B]) begin
            raw_good = raw_good & flags[0];
        end
        // Counts are parameters so a bench can shorten them
        case (gctl_q[1:0])
            2'b00: dly_lim = 25'(DLY_20_CYC);
            2'b01: dly_lim = 25'(DLY_100_CYC);
            2'b10: dly_lim = 25'(DLY_200_CYC);
            default: dly_lim = 25'(DLY_400_CYC);
        endcase
    end

    // Good pin rises only after the delay; falls at once
    always_comb begin
        dly_d = dly_q;
        pin_d = 1'b0;
        // One bad cycle restarts the whole delay
        if (!raw_good) begin
            dly_d = '0;
        end else if (dly_q < dly_lim) begin
            dly_d = dly_q + 25'd1;
        end else begin
            pin_d = 1'b1;
        end
        // Timer tick runs every cycle, or every other one when slowed
        half_d = ~half_q;
        tick_d = 1'b1;
        if (chg2_q[B_HALF_RATE] &&
            (sense.thermal_loop_active || sense.path_loop_active)) begin
            tick_d = half_q;
        end
        offst_d = offst_q |
            (off_q && !sense.power_enable_pin);
    end

    // Timer, good-pin and off-state flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dly_q <= '0;
            pin_q <= 1'b0;
            half_q <= 1'b0;
            tick_q <= 1'b0;
            offst_q <= 1'b0;
        end else begin
            dly_q <= dly_d;
            pin_q <= pin_d;
            half_q <= half_d;
            tick_q <= tick_d;
            offst_q <= offst_d;
        end
    end
    assign rails_good_pin = pin_q;
    assign timer_tick_enable = tick_q;
    assign off_state = offst_q;

    // ------------------------------------------------------------
    // Decoded controls to the analog sections
    // ------------------------------------------------------------
    // Next and registered decode
    pcs_ctrl_type ctrl_d;
    pcs_ctrl_type ctrl_q;
    always_comb begin
        ctrl_d.timer_half_rate = chg2_q[B_HALF_RATE];
        ctrl_d.precharge_threshold_select = chg2_q[B_PRE_THRESH];
        ctrl_d.charge_voltage_select = chg2_q[5:4];
        ctrl_d.charge_current_select = chg3_q[7:6];
        ctrl_d.path_threshold_select = chg3_q[5:4];
        ctrl_d.precharge_time_select = chg3_q[B_PRE_TIME];
        ctrl_d.termination_factor = chg3_q[2:1];
        ctrl_d.charge_temp_window = chg3_q[0];
        ctrl_d.sink_enable = blc_q[B_SINK_EN];
        ctrl_d.sink_level_select = blc_q[B_SINK_LEVEL];
        ctrl_d.dim_frequency_select = blc_q[1:0];
        // Duty above the top code means fully dark
        if (duty_q[6:0] > DUTY_MAX_CODE) begin
            ctrl_d.dim_duty_percent = '0;
        end else begin
            ctrl_d.dim_duty_percent = duty_q[6:0] + 7'd1;
        end
        // Codes with no source leave the mux output floating
        ctrl_d.analog_source_select = mux_q[2:0];
        ctrl_d.analog_out_enable = (mux_q[2:0] != 3'h0) &&
            (mux_q[2:0] < 3'h6);
        ctrl_d.buck_a_external_adjust = buck_q[B_EXT_ADJ];
        // Codes past the top saturate to the top voltage
        if (buck_q[5:0] >= BUCK_TOP_CODE) begin
            ctrl_d.buck_a_voltage_code = BUCK_TOP_CODE;
        end else begin
            ctrl_d.buck_a_voltage_code = buck_q[5:0];
        end
    end

    // Decode is registered so every control leaves a flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    assign ctrl = ctrl_q;
endmodule

// >>> tb/pcs_host.sv
// Host model issuing single-byte strobed register accesses
`timescale 1ns/1ps
module pcs_host
    import pcs_pkg::*;
(
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data,
    output logic xact_end,
    input wire logic [7:0] rd_data
);
    // Idle bus at time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        xact_end = 1'b0;
    end
    // Released bus shows inverted junk, never the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge clk);
        wr_en <= 1'b0;
        addr <= ~a;
        wr_data <= ~v;
    endtask
    // Data is taken one edge after the strobe is seen
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        v = rd_data;
    endtask
    // Key write arming the next protected write
    task automatic unlock;
        wr(OFS_KEY, UNLOCK_VALUE);
    endtask
    // End of one bus transaction
    task automatic stop;
        @(posedge clk);
        xact_end <= 1'b1;
        @(posedge clk);
        xact_end <= 1'b0;
    endtask
endmodule

// >>> tb/pcs_regs_sva.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
module pcs_regs_sva
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic xact_end,
    input wire pcs_pkg::pcs_sense_type sense,
    input wire logic [7:0] rd_data,
    input wire pcs_pkg::pcs_ctrl_type ctrl,
    input wire logic rails_good_pin,
    input wire logic off_state,
    input wire logic timer_tick_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic armed_q;
    logic armed_d;
    logic slow_w;
    // --------------------------------------------------------
    // Helper logic
    // --------------------------------------------------------
    // Any write other than the key value spends the unlock
    always_comb begin
        armed_d = armed_q;
        if (wr_en) begin
            armed_d = (addr == OFS_KEY) && (wr_data == UNLOCK_VALUE);
        end
    end
    // Unlock state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
        end
    end
    // Timers slowed only with the bit set and a loop active
    assign slow_w = ctrl.timer_half_rate &&
        (sense.thermal_loop_active || sense.path_loop_active);
    // --------------------------------------------------------
    // Assertions
    // --------------------------------------------------------
    a_sink_follow: assert property (
        wr_en && addr == OFS_BL_CTRL |-> ##2
        ctrl.sink_enable == $past(wr_data[B_SINK_EN], 2) &&
        ctrl.dim_frequency_select == $past(wr_data[1:0], 2))
        else $error("Backlight control decode mismatch");
    a_duty_map: assert property (
        wr_en && addr == OFS_BL_DUTY |-> ##2 ctrl.dim_duty_percent ==
        ($past(wr_data[6:0], 2) > DUTY_MAX_CODE ? 7'h00 :
        $past(wr_data[6:0], 2) + 7'h01))
        else $error("Duty decode mismatch");
    a_mux_float: assert property (
        ctrl.analog_out_enable == (ctrl.analog_source_select != 3'h0 &&
        ctrl.analog_source_select < 3'h6))
        else $error("Mux enable mismatch");
    a_buck_armed: assert property (
        wr_en && addr == OFS_BUCK_ONE && armed_q |-> ##2
        ctrl.buck_a_external_adjust == $past(wr_data[B_EXT_ADJ], 2) &&
        ctrl.buck_a_voltage_code == ($past(wr_data[5:0], 2) >
        BUCK_TOP_CODE ? BUCK_TOP_CODE : $past(wr_data[5:0], 2)))
        else $error("Buck write not applied");
    a_buck_locked: assert property (
        wr_en && addr == OFS_BUCK_ONE && !armed_q |-> ##2
        $stable(ctrl.buck_a_voltage_code))
        else $error("Locked buck write took effect");
    a_key_clear: assert property (
        xact_end && !wr_en ##1 !wr_en ##1 rd_en && addr == OFS_KEY |=>
        rd_data == 8'h00)
        else $error("Key not cleared after transaction");
    a_state_bits: assert property (
        rd_en && addr == OFS_STATE && $stable(sense) |=> rd_data[3:0] ==
        {$past(sense.adapter_present), $past(sense.usb_supply_present),
        1'b0, !$past(sense.button_input_pin)})
        else $error("Status bits wrong");
    a_off_gate: assert property (
        $rose(off_state) |-> !$past(sense.power_enable_pin))
        else $error("Off state with enable pin high");
    a_tick_full: assert property (
        !slow_w [*3] |-> timer_tick_enable)
        else $error("Timer slowed without cause");
    a_tick_half: assert property (
        slow_w [*3] |-> timer_tick_enable != $past(timer_tick_enable))
        else $error("Timer not at half rate");
    a_pin_drop: assert property (
        $fell(sense.rail_in_regulation[4]) |-> ##[1:2] !rails_good_pin)
        else $error("Good pin stayed high");
    c_armed: cover property (wr_en && addr == OFS_BUCK_ONE && armed_q);
    c_off: cover property ($rose(off_state));
    c_pin: cover property ($rose(rails_good_pin));
endmodule
bind pcs_regs pcs_regs_sva pcs_regs_sva_i (.clk(clk), .rst_b(rst_b),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .xact_end(xact_end), .sense(sense), .rd_data(rd_data), .ctrl(ctrl),
    .rails_good_pin(rails_good_pin), .off_state(off_state),
    .timer_tick_enable(timer_tick_enable));

// >>> tb/tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb;
    import pcs_pkg::*;
    logic clk;
    logic rst_b;
    logic wr_en, rd_en, xact_end;
    logic [7:0] addr, wr_data, rd_data, d;
    pcs_sense_type sense;
    pcs_ctrl_type ctrl;
    logic rails_good_pin, off_state, timer_tick_enable;
    int err_count, samples_checked, n;
    // Short pin delays keep the run brief
    pcs_regs #(.BUCK_ONE_RESET(8'h18), .DLY_20_CYC(5), .DLY_100_CYC(10),
        .DLY_200_CYC(20), .DLY_400_CYC(40)) pcs_regs_i (.clk(clk),
        .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .xact_end(xact_end), .sense(sense),
        .rd_data(rd_data), .ctrl(ctrl), .rails_good_pin(rails_good_pin),
        .off_state(off_state), .timer_tick_enable(timer_tick_enable));
    pcs_host pcs_host_i (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .xact_end(xact_end),
        .rd_data(rd_data));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // --------------------------------------------------------
    // Checking helpers
    // --------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        pcs_host_i.rd(a, d);
        chk(d, e);
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Wait until the good pin rises, counting edges
    task automatic wait_pin;
        n = 0;
        while (rails_good_pin !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
    endtask
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic t_reset;
        rdc(OFS_CHG_TWO, 8'h80);
        rdc(OFS_CHG_THREE, 8'hB2);
        rdc(OFS_BL_CTRL, 8'h01);
        rdc(OFS_BL_DUTY, 8'h00);
        rdc(OFS_MUX, 8'h00);
        rdc(OFS_STATE, 8'h00);
        rdc(OFS_KEY, 8'h00);
        rdc(OFS_GOOD, 8'h00);
        rdc(OFS_GOOD_CTRL, 8'h0C);
        rdc(OFS_BUCK_ONE, 8'h18);
        rdc(8'h0F, 8'h00);
        chk(8'(ctrl.dim_frequency_select), 8'h01);
    endtask
    task automatic t_charger;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {i[1:0], i[1:0], i[0], i[1:0], i[0]};
            pcs_host_i.wr(OFS_CHG_THREE, v);
            rdc(OFS_CHG_THREE, v);
            chk(8'(ctrl.charge_current_select), 8'(i));
            chk(8'({ctrl.path_threshold_select, ctrl.precharge_time_select,
                ctrl.termination_factor}), v[5:1]);
            chk(8'(ctrl.charge_temp_window), 8'(v[0]));
        end
        pcs_host_i.wr(OFS_CHG_TWO, 8'hFF);
        rdc(OFS_CHG_TWO, 8'hF0);
        chk(8'({ctrl.precharge_threshold_select,
            ctrl.charge_voltage_select}), 8'h07);
    endtask
    task automatic t_light;
        logic [7:0] duty [6] = '{8'h00, 8'h01, 8'h62, 8'h63, 8'h64, 8'h7F};
        for (int i = 0; i < 8; i++) begin
            pcs_host_i.wr(OFS_MUX, 8'(i));
            pcs_host_i.wr(OFS_BL_CTRL, 8'({i[2], i[0], i[1:0]}));
            rdc(OFS_MUX, 8'(i));
            chk(8'(ctrl.analog_out_enable), 8'(i > 0 && i < 6));
            chk(8'({ctrl.sink_enable, ctrl.sink_level_select,
                ctrl.dim_frequency_select}),
                8'({i[2], i[0], i[1:0]}));
        end
        foreach (duty[k]) begin
            pcs_host_i.wr(OFS_BL_DUTY, duty[k]);
            pcs_host_i.rd(OFS_BL_DUTY, d);
            chk(8'(ctrl.dim_duty_percent),
                duty[k] > 8'h63 ? 8'h00 : duty[k] + 8'h01);
        end
    endtask
    // Count ticks over eight cycles per rate bit and per active loop
    task automatic t_timer;
        for (int s = 3; s >= 0; s--) begin
            pcs_host_i.wr(OFS_CHG_TWO, {s[1], 7'h00});
            @(posedge clk);
            sense.path_loop_active <= s[0];
            sense.thermal_loop_active <= !s[0];
            repeat (4) @(posedge clk);
            n = 0;
            repeat (8) begin
                @(posedge clk);
                n += int'(timer_tick_enable);
            end
            chk(8'(n), s[1] ? 8'h04 : 8'h08);
        end
        sense.path_loop_active <= 1'b0;
        sense.thermal_loop_active <= 1'b0;
    endtask
    task automatic t_status;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            sense.adapter_present <= i[0];
            sense.usb_supply_present <= i[1];
            sense.button_input_pin <= i[2];
            repeat (2) @(posedge clk);
            rdc(OFS_STATE, 8'({i[0], i[1], 1'b0, !i[2]}));
        end
    endtask
    task automatic t_good;
        @(posedge clk);
        sense.rail_in_regulation <= 7'h1C;
        sense.switch_rail_a_is_switch <= 1'b1;
        sense.switch_rail_b_is_switch <= 1'b1;
        wait_pin();
        chk(8'(n >= 5 && n <= 8), 8'h01);
        rdc(OFS_GOOD, 8'h7C);
        pcs_host_i.wr(OFS_GOOD_CTRL, 8'h01);
        rdc(OFS_GOOD_CTRL, 8'h0C);
        pcs_host_i.unlock();
        pcs_host_i.wr(OFS_GOOD_CTRL, 8'h01);
        rdc(OFS_GOOD_CTRL, 8'h01);
        chk(8'(rails_good_pin), 8'h00);
        sense.rail_in_regulation <= 7'h1F;
        wait_pin();
        chk(8'(n >= 10 && n <= 13), 8'h01);
        sense.rail_in_regulation <= 7'h0F;
        repeat (3) @(posedge clk);
        chk(8'(rails_good_pin), 8'h00);
    endtask
    task automatic t_key;
        pcs_host_i.unlock();
        pcs_host_i.stop();
        rdc(OFS_KEY, 8'h00);
        pcs_host_i.unlock();
        pcs_host_i.wr(OFS_MUX, 8'h00);
        pcs_host_i.wr(OFS_BUCK_ONE, 8'h20);
        rdc(OFS_BUCK_ONE, 8'h18);
        pcs_host_i.unlock();
        pcs_host_i.wr(OFS_BUCK_ONE, 8'hB9);
        rdc(OFS_BUCK_ONE, 8'hB9);
        chk(8'({ctrl.buck_a_external_adjust, ctrl.buck_a_voltage_code}),
            8'h78);
    endtask
    task automatic t_off;
        pcs_host_i.wr(OFS_STATE, 8'h80);
        rdc(OFS_STATE, 8'h8C);
        chk(8'(off_state), 8'h00);
        sense.power_enable_pin <= 1'b0;
        repeat (3) @(posedge clk);
        chk(8'(off_state), 8'h01);
        rdc(OFS_STATE, 8'h0C);
    endtask
    // Main sequence
    initial begin
        err_count = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        sense = '0;
        sense.button_input_pin = 1'b1;
        sense.power_enable_pin = 1'b1;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_charger();
        t_light();
        t_timer();
        t_status();
        t_good();
        t_key();
        t_off();
        end_sim();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        end_sim();
    end
endmodule
